// ===== core/rcadc_core.sv
// Counter, register and APB slave logic of the RC oscillation converter.
`timescale 1ns/10ps
module rcadc_core (
    input wire logic sys_clk, // System clock, 100 MHz.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [15:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error.
    input wire rcadc_pkg::rcadc_clk_in_t clk_in, // Asynchronous clocks.
    output rcadc_pkg::rcadc_osc_ctl_t osc_ctl, // Oscillator control.
    output logic oscillation_monitor_out, // Selected oscillation.
    output logic converter_irq // Overflow request pulse.
);
    import rcadc_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Synchronisers: two flops per raw clock, then an edge history flop.
    // Every source here is asynchronous to sys_clk; only the second stage
    // and later are read, and a source must stay below a quarter of the
    // system clock or edges are lost between samples.
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [6:0] sync3;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 7'h00;
            sync2 <= 7'h00;
            sync3 <= 7'h00;
        end else begin
            sync1 <= clk_in;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Rising edges seen only on the second stage and later.
    logic [6:0] rise;
    assign rise = sync2 & ~sync3;

    //////////////////////////////////////////////////////////////////////////
    // Registers.
    logic [7:0] converter_mode;
    logic conversion_run;
    logic [23:0] base_preset;
    logic [23:0] osc_preset;
    // Two independent 24-bit counters; presets are kept apart for readback.
    logic [23:0] base_count;
    logic [23:0] osc_count;
    logic base_counter_overflow;
    logic osc_counter_overflow;
    logic [2:0] hs_div;

    logic [3:0] oscillation_mode_sel;
    logic irq_source_select;
    logic [2:0] base_clock_sel;
    assign oscillation_mode_sel = converter_mode[MODE_OSC_LSB +: 4];
    assign irq_source_select = converter_mode[MODE_IRQ_BIT];
    assign base_clock_sel = converter_mode[MODE_BCLK_LSB +: 3];

    // Byte index decode shared by write and read paths.
    // Index bit 2 splits the two counters and bits 1..0 pick the byte;
    // an unmapped address gives the all-ones index.
    function automatic logic [3:0] reg_index(input logic [15:0] a);
        if (a == OFF_BASE_LOW) begin
            reg_index = 4'h0;
        end else if (a == OFF_BASE_MID) begin
            reg_index = 4'h1;
        end else if (a == OFF_BASE_HIGH) begin
            reg_index = 4'h2;
        end else if (a == OFF_OSC_LOW) begin
            reg_index = 4'h4;
        end else if (a == OFF_OSC_MID) begin
            reg_index = 4'h5;
        end else if (a == OFF_OSC_HIGH) begin
            reg_index = 4'h6;
        end else if (a == OFF_MODE) begin
            reg_index = 4'h8;
        end else if (a == OFF_CONTROL) begin
            reg_index = 4'h9;
        end else begin
            reg_index = 4'hf;
        end
    endfunction : reg_index

    logic access;
    logic wr;
    logic [3:0] idx;
    logic [7:0] wbyte;
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign idx = reg_index(paddr);
    assign wbyte = pwdata[7:0];

    // Write strobes per register group, decoded once and shared by the
    // processes below so that every process sees the same decode.
    logic wr_base;
    logic wr_osc;
    logic wr_mode;
    logic wr_ctrl;
    logic run_start;
    assign wr_base = wr & (idx[3:2] == 2'b00) & (idx[1:0] != 2'h3);
    assign wr_osc = wr & (idx[3:2] == 2'b01) & (idx[1:0] != 2'h3);
    assign wr_mode = wr & (idx == 4'h8);
    assign wr_ctrl = wr & (idx == 4'h9);
    // A run write with bit 0 set also rearms both overflow flags.
    assign run_start = wr_ctrl & wbyte[CTRL_RUN_BIT];

    //////////////////////////////////////////////////////////////////////////
    // Base clock selection; the high clock divider runs always.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hs_div <= 3'h0;
        end else if (rise[4]) begin
            hs_div <= hs_div + 3'h1;
        end
    end

    // Divided high clock ticks: one high clock edge out of 2, 4 or 8.
    // Sharing one free divider means the first divided tick after a
    // mode change may come early; a gate of many ticks hides this.
    logic hs_d2_tick;
    logic hs_d4_tick;
    logic hs_d8_tick;
    assign hs_d2_tick = rise[4] & hs_div[0];
    assign hs_d4_tick = rise[4] & (hs_div[1:0] == 2'h3);
    assign hs_d8_tick = rise[4] & (hs_div == 3'h7);

    // Base tick multiplexer; the two prohibited codes select nothing.
    logic base_tick;
    always_comb begin
        case (base_clock_sel)
            RCADC_BC_LOW: base_tick = rise[6];
            RCADC_BC_LOW_X2: base_tick = rise[5];
            RCADC_BC_HIGH: base_tick = rise[4];
            RCADC_BC_HIGH_D2: base_tick = hs_d2_tick;
            RCADC_BC_HIGH_D4: base_tick = hs_d4_tick;
            RCADC_BC_HIGH_D8: base_tick = hs_d8_tick;
            default: base_tick = 1'b0;
        endcase
    end

    // Oscillator clock: one source per mode, prohibited modes give none.
    logic osc_tick;
    logic osc_level;
    always_comb begin
        osc_tick = 1'b0;
        osc_level = 1'b0;
        if (oscillation_mode_sel == RCADC_OM_EXT0) begin
            osc_tick = rise[3];
            osc_level = sync2[3];
        end else if (oscillation_mode_sel == RCADC_OM_EXT1) begin
            osc_tick = rise[2];
            osc_level = sync2[2];
        end else if (!oscillation_mode_sel[3] && !oscillation_mode_sel[2]
                     || oscillation_mode_sel == RCADC_OM_RS0_CT0) begin
            osc_tick = rise[1];
            osc_level = sync2[1];
        end else if (!oscillation_mode_sel[3]) begin
            osc_tick = rise[0];
            osc_level = sync2[0];
        end
    end

    // Source map of the synchronised vector, msb first: low clock, doubled
    // low clock, high clock, channel 0 pin, channel 1 pin, channel 0
    // oscillator, channel 1 oscillator.  Only one of the last four is
    // looked at in any mode, so an idle source cannot disturb a count.

    //////////////////////////////////////////////////////////////////////////
    // Counters.  Presets load while stopped; counting only while running.
    // A byte write loads preset and live count alike, so a write during a
    // conversion restarts the gate from the new value; software normally
    // writes only while stopped.
    logic base_wrap;
    logic osc_wrap;
    assign base_wrap = conversion_run & base_tick & (&base_count);
    assign osc_wrap = conversion_run & osc_tick & (&osc_count);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            base_count <= RESET_COUNT;
            base_preset <= RESET_COUNT;
        end else if (wr_base) begin
            base_preset[idx[1:0]*8 +: 8] <= wbyte;
            base_count[idx[1:0]*8 +: 8] <= wbyte;
        end else if (conversion_run && base_tick) begin
            base_count <= base_count + 24'h00_0001;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_count <= RESET_COUNT;
            osc_preset <= RESET_COUNT;
        end else if (wr_osc) begin
            osc_preset[idx[1:0]*8 +: 8] <= wbyte;
            osc_count[idx[1:0]*8 +: 8] <= wbyte;
        end else if (conversion_run && osc_tick) begin
            osc_count <= osc_count + 24'h00_0001;
        end
    end

    // Overflow flags: set on wrap, cleared when a new run starts.  A wrap
    // in the same cycle as a run write wins, so no overflow is lost.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            base_counter_overflow <= 1'b0;
        end else if (base_wrap) begin
            base_counter_overflow <= 1'b1;
        end else if (run_start) begin
            base_counter_overflow <= 1'b0;
        end
    end

    // Same rule for the oscillator counter's flag.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_counter_overflow <= 1'b0;
        end else if (osc_wrap) begin
            osc_counter_overflow <= 1'b1;
        end else if (run_start) begin
            osc_counter_overflow <= 1'b0;
        end
    end

    // Mode register: plain storage, decoded by the multiplexers above.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            converter_mode <= RESET_BYTE;
        end else if (wr_mode) begin
            converter_mode <= wbyte;
        end
    end

    // Run bit; an overflow beats a simultaneous software write, so a
    // conversion that ends on the write cycle still stops.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            conversion_run <= 1'b0;
        end else if (base_wrap || osc_wrap) begin
            conversion_run <= 1'b0;
        end else if (wr_ctrl) begin
            conversion_run <= wbyte[CTRL_RUN_BIT];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, error on unmapped addresses.
    function automatic logic [7:0] read_byte(input logic [3:0] i);
        logic [23:0] b;
        logic [23:0] o;
        b = conversion_run ? base_preset : base_count;
        o = conversion_run ? osc_preset : osc_count;
        case (i)
            4'h0: read_byte = b[7:0];
            4'h1: read_byte = b[15:8];
            4'h2: read_byte = b[23:16];
            4'h4: read_byte = o[7:0];
            4'h5: read_byte = o[15:8];
            4'h6: read_byte = o[23:16];
            4'h8: read_byte = converter_mode;
            4'h9: read_byte = {7'h00, conversion_run};
            default: read_byte = 8'h00;
        endcase
    endfunction : read_byte

    // Ready: one cycle after every setup cycle, so zero wait states.  The
    // master must hold its request through that access cycle.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & ~penable;
        end
    end

    // Error response for addresses outside the eight byte registers.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel & ~penable & (idx == 4'hf);
        end
    end

    // Read data is captured in the setup cycle.  A count that moves in
    // the access cycle is therefore read one clock old, which is harmless
    // because counts are read only once a conversion has stopped.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= {24'h00_0000, read_byte(idx)};
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Oscillator enables: channel 0 owns modes 1-4, channel 1 modes 5-6.
    // The external pin modes and the prohibited codes leave both off, and
    // a cleared run bit stops whichever oscillator was running.
    logic ch0_mode;
    logic ch1_mode;
    assign ch0_mode = oscillation_mode_sel inside {[4'h1:4'h4]};
    assign ch1_mode = oscillation_mode_sel inside {[4'h5:4'h6]};
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_ctl <= '0;
        end else begin
            osc_ctl.osc_ch0_enable <= conversion_run & ch0_mode;
            osc_ctl.osc_ch1_enable <= conversion_run & ch1_mode;
            osc_ctl.pin_drive_sel <= conversion_run
                ? {3'h0, oscillation_mode_sel} : 7'h00;
        end
    end

    // Monitor pin: the synchronised level of the counted source, held low
    // while stopped.  It lags the source by three clocks, fine for a probe.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            oscillation_monitor_out <= 1'b0;
        end else begin
            oscillation_monitor_out <= conversion_run & osc_level;
        end
    end

    // Interrupt pulse from the selected counter, only on the wrap that
    // first sets its flag, so there is at most one request per conversion.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            converter_irq <= 1'b0;
        end else if (irq_source_select) begin
            converter_irq <= osc_wrap & ~osc_counter_overflow;
        end else begin
            converter_irq <= base_wrap & ~base_counter_overflow;
        end
    end
endmodule : rcadc_core

// ===== shared/rcadc_pkg.sv
// Package with register map, field layout and types of the RC converter.
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Two 24-bit counters plus mode and control.
// - Base counter bytes low, mid, high.
// - Oscillator counter bytes low, mid, high.
// - Running reads return last written preset.
// - Stopped reads return accumulated count.
// - Mode bits 3-0 select oscillation source.
// - External modes count the channel input pin.
// - Only one channel source active at once.
// - Bit 4 picks which overflow raises interrupt.
// - Bits 7-5 select base clock source.
// - Base select 110/111 gives no clock.
// - Control bit 0 runs, reset value zero.
// - Any overflow clears run bit.
// - Running counters advance on their clocks.
// - Stopped run halts oscillator and counters.
// - Counting past all-ones sets overflow flag.
// - Preset base counter sets gate time.
package rcadc_pkg;
    localparam int CNT_W = 24;
    localparam logic [15:0] OFF_BASE_LOW = 16'hf300;
    localparam logic [15:0] OFF_BASE_MID = 16'hf301;
    localparam logic [15:0] OFF_BASE_HIGH = 16'hf302;
    localparam logic [15:0] OFF_OSC_LOW = 16'hf304;
    localparam logic [15:0] OFF_OSC_MID = 16'hf305;
    localparam logic [15:0] OFF_OSC_HIGH = 16'hf306;
    localparam logic [15:0] OFF_MODE = 16'hf308;
    localparam logic [15:0] OFF_CONTROL = 16'hf309;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [23:0] RESET_COUNT = 24'h00_0000;
    localparam int MODE_OSC_LSB = 0;
    localparam int MODE_IRQ_BIT = 4;
    localparam int MODE_BCLK_LSB = 5;
    localparam int CTRL_RUN_BIT = 0;

    typedef enum logic [3:0] {
        RCADC_OM_EXT0 = 4'h0,
        RCADC_OM_RS0_CS0 = 4'h1,
        RCADC_OM_RT0_CS0 = 4'h2,
        RCADC_OM_RT01_CS0 = 4'h3,
        RCADC_OM_RS0_CT0 = 4'h4,
        RCADC_OM_RS1_CS1 = 4'h5,
        RCADC_OM_RT1_CS1 = 4'h6,
        RCADC_OM_EXT1 = 4'h7
    } rcadc_osc_mode_t;

    typedef enum logic [2:0] {
        RCADC_BC_LOW = 3'h0,
        RCADC_BC_LOW_X2 = 3'h1,
        RCADC_BC_HIGH = 3'h2,
        RCADC_BC_HIGH_D2 = 3'h3,
        RCADC_BC_HIGH_D4 = 3'h4,
        RCADC_BC_HIGH_D8 = 3'h5
    } rcadc_base_sel_t;

    // Raw clock-like inputs from the clock generator and pins.
    typedef struct packed {
        logic low_speed_clock;
        logic low_speed_x2_clock;
        logic high_speed_clock;
        logic ext_clock_input_ch0;
        logic ext_clock_input_ch1;
        logic osc_ch0;
        logic osc_ch1;
    } rcadc_clk_in_t;

    // Oscillator enables toward the analog circuits.
    typedef struct packed {
        logic [6:0] pin_drive_sel;
        logic osc_ch0_enable;
        logic osc_ch1_enable;
    } rcadc_osc_ctl_t;
endpackage : rcadc_pkg

// ===== verif/rcadc_core_assertions.sv
// Port-level checker for the RC oscillation converter core.
`timescale 1ns/10ps
module rcadc_core_assertions (
    input wire logic sys_clk, // System clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [15:0] paddr, // APB address.
    input wire logic [31:0] pwdata, // APB write data.
    input wire logic [31:0] prdata, // APB read data.
    input wire logic pready, // APB ready.
    input wire logic pslverr, // APB error.
    input wire rcadc_pkg::rcadc_clk_in_t clk_in, // Raw clocks.
    input wire rcadc_pkg::rcadc_osc_ctl_t osc_ctl, // Oscillator control.
    input wire logic oscillation_monitor_out, // Monitor.
    input wire logic converter_irq // Overflow request.
);
    import rcadc_pkg::*;
    logic mapped;
    //////////////////////////////////////////////////////////////////////
    // Decode of the eight byte registers; everything else must be refused.
    assign mapped = paddr inside {OFF_BASE_LOW, OFF_BASE_MID, OFF_BASE_HIGH,
        OFF_OSC_LOW, OFF_OSC_MID, OFF_OSC_HIGH, OFF_MODE, OFF_CONTROL};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_stop_write;
        s_access ##0 pready && pwrite && paddr == OFF_CONTROL && !pwdata[0];
    endsequence
    //////////////////////////////////////////////////////////////////////
    // Bus timing, decode and the oscillator enables.
    a_ready_zero_wait: assert property (s_setup |=> pready)
        else $error("pready missing in access cycle");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_ready_in_access: assert property (pready |-> s_access)
        else $error("pready outside an access phase");
    a_err_decode: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address decode");
    a_byte_wide: assert property (pready |-> prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    a_irq_pulse: assert property (converter_irq |=> !converter_irq)
        else $error("interrupt request longer than one cycle");
    a_one_channel: assert property (
        !(osc_ctl.osc_ch0_enable && osc_ctl.osc_ch1_enable))
        else $error("both oscillators enabled");
    a_stop_halts: assert property (s_stop_write |-> ##2
        !osc_ctl.osc_ch0_enable && !osc_ctl.osc_ch1_enable)
        else $error("oscillator still enabled after stop");
endmodule : rcadc_core_assertions

bind rcadc_core rcadc_core_assertions u_chk (.sys_clk(sys_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clk_in(clk_in), .osc_ctl(osc_ctl),
    .oscillation_monitor_out(oscillation_monitor_out),
    .converter_irq(converter_irq));

// ===== verif/rcadc_osc_model.sv
// Behavioural model of the oscillators, input pins and base clocks.
`timescale 1ns/10ps
module rcadc_osc_model (
    output rcadc_pkg::rcadc_clk_in_t clk_in, // Clocks toward the core.
    input wire rcadc_pkg::rcadc_osc_ctl_t osc_ctl // Oscillator enables.
);
    import rcadc_pkg::*;
    logic lsc = 1'b0;
    logic x2 = 1'b0;
    logic hsc = 1'b0;
    logic e0 = 1'b0;
    logic e1 = 1'b0;
    logic o0 = 1'b0;
    logic o1 = 1'b0;
    //////////////////////////////////////////////////////////////////////
    // Generator clocks and external pins run free, all below sys_clk/4.
    always #200 lsc = ~lsc;
    always #100 x2 = ~x2;
    always #50 hsc = ~hsc;
    always #70 e0 = ~e0;
    always #90 e1 = ~e1;
    // A disabled oscillator stops and rests low, so stale edges never count.
    always begin
        #60;
        o0 = osc_ctl.osc_ch0_enable ? ~o0 : 1'b0;
        o1 = osc_ctl.osc_ch1_enable ? ~o1 : 1'b0;
    end
    assign clk_in = {lsc, x2, hsc, e0, e1, o0, o1};
endmodule : rcadc_osc_model

// ===== verif/test_rc_oscillation_adc_counters.sv
// Self-checking testbench for the RC oscillation converter core.
`timescale 1ns/10ps
module test_rc_oscillation_adc_counters;
    import rcadc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, converter_irq, mon;
    rcadc_clk_in_t clk_in;
    rcadc_osc_ctl_t osc_ctl;
    logic [7:0] rq;
    logic re;
    logic [23:0] cnt;
    int err_total = 0;
    int checks = 0;
    int irqs = 0;
    int mons = 0;
    int i;
    logic [15:0] regs [8] = '{OFF_BASE_LOW, OFF_BASE_MID, OFF_BASE_HIGH,
        OFF_OSC_LOW, OFF_OSC_MID, OFF_OSC_HIGH, OFF_MODE, OFF_CONTROL};
    //////////////////////////////////////////////////////////////////////
    // Clock, interrupt pulse counter, design and far-side model.
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (converter_irq === 1'b1) irqs++;
    always @(posedge sys_clk) if (mon === 1'b1) mons++;
    rcadc_core dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clk_in(clk_in), .osc_ctl(osc_ctl), .oscillation_monitor_out(mon),
        .converter_irq(converter_irq));
    rcadc_osc_model partner (.clk_in(clk_in), .osc_ctl(osc_ctl));
    //////////////////////////////////////////////////////////////////////
    // Verdict, comparison and bus tasks.
    task automatic wrap_up();
        if (err_total == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Starts one edge late so two transfers never drive psel in one step.
    task automatic xfer(input logic w, input logic [15:0] a,
            input logic [7:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            wrap_up();
        end
        rq = prdata[7:0];
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic rd24(input logic [15:0] a);
        xfer(1'b0, a, 8'h00);
        cnt[7:0] = rq;
        xfer(1'b0, a + 16'h0001, 8'h00);
        cnt[15:8] = rq;
        xfer(1'b0, a + 16'h0002, 8'h00);
        cnt[23:16] = rq;
    endtask : rd24
    task automatic wr24(input logic [15:0] a, input logic [23:0] v);
        xfer(1'b1, a, v[7:0]);
        xfer(1'b1, a + 16'h0001, v[15:8]);
        xfer(1'b1, a + 16'h0002, v[23:16]);
    endtask : wr24
    task automatic wait_stop();
        int n;
        n = 0;
        do begin
            xfer(1'b0, OFF_CONTROL, 8'h00);
            n++;
        end while (rq[0] !== 1'b0 && n < 2000);
        if (n >= 2000) begin
            err_total++;
            wrap_up();
        end
    endtask : wait_stop
    //////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 8; i++) begin
            xfer(1'b0, regs[i], 8'h00);
            chk(rq, 8'h00);
        end
        for (i = 0; i < 7; i++) begin
            xfer(1'b1, regs[i], 8'h3c + 8'(i));
            xfer(1'b0, regs[i], 8'h00);
            chk(rq, 8'h3c + 8'(i));
        end
        xfer(1'b1, OFF_CONTROL, 8'hfe);
        xfer(1'b0, OFF_CONTROL, 8'h00);
        // Only the run bit is stored; the upper control bits read zero.
        chk(rq, 8'h00);
        xfer(1'b1, OFF_CONTROL, 8'h00);
        // The gap between the counter blocks must be refused.
        xfer(1'b1, 16'hf303, 8'hff);
        chk(re, 1'b1);
        xfer(1'b0, 16'hf303, 8'h00);
        chk({re, rq}, 9'h100);
        // Every oscillation mode against a rotating base clock source.
        for (i = 0; i < 8; i++) begin
            // Each pass sets the converter up afresh after the last stop.
            xfer(1'b1, OFF_MODE, {3'(i % 6), 1'b0, 4'(i)});
            wr24(OFF_BASE_LOW, 24'hff_fff0);
            wr24(OFF_OSC_LOW, 24'h00_0000);
            irqs = 0;
            xfer(1'b1, OFF_CONTROL, 8'h01);
            rd24(OFF_BASE_LOW);
            chk(cnt, 24'hff_fff0);
            chk({osc_ctl.osc_ch0_enable, osc_ctl.osc_ch1_enable}, (i inside
                {[1:4]}) ? 2'b10 : (i inside {5, 6}) ? 2'b01 : 2'b00);
            wait_stop();
            chk(irqs, 1);
            rd24(OFF_BASE_LOW);
            chk(cnt, 24'h00_0000);
            rd24(OFF_OSC_LOW);
            chk(cnt != 24'h00_0000, 1'b1);
        end
        // Oscillator overflow as interrupt source, with no base clock.
        xfer(1'b1, OFF_MODE, 8'hd7);
        wr24(OFF_BASE_LOW, 24'h00_0010);
        wr24(OFF_OSC_LOW, 24'hff_fff0);
        irqs = 0;
        xfer(1'b1, OFF_CONTROL, 8'h01);
        wait_stop();
        chk(irqs, 1);
        rd24(OFF_BASE_LOW);
        chk(cnt, 24'h00_0010);
        rd24(OFF_OSC_LOW);
        chk(cnt, 24'h00_0000);
        // A prohibited oscillation code runs no source at all.
        xfer(1'b1, OFF_MODE, 8'hc8);
        xfer(1'b1, OFF_CONTROL, 8'h01);
        repeat (40) @(posedge sys_clk);
        chk({osc_ctl.osc_ch0_enable, osc_ctl.osc_ch1_enable}, 2'b00);
        xfer(1'b1, OFF_CONTROL, 8'h00);
        rd24(OFF_OSC_LOW);
        chk(cnt, 24'h00_0000);
        // Stopping a running oscillator drops its enable and pin drive.
        xfer(1'b1, OFF_MODE, 8'hc2);
        xfer(1'b1, OFF_CONTROL, 8'h01);
        repeat (2) @(posedge sys_clk);
        chk({osc_ctl.pin_drive_sel, osc_ctl.osc_ch0_enable}, 8'h05);
        xfer(1'b1, OFF_CONTROL, 8'h00);
        repeat (2) @(posedge sys_clk);
        chk({osc_ctl.pin_drive_sel, osc_ctl.osc_ch0_enable}, 8'h00);
        // Software stop freezes the count and holds the monitor pin low.
        xfer(1'b1, OFF_MODE, 8'hc0);
        mons = 0;
        xfer(1'b1, OFF_CONTROL, 8'h01);
        repeat (60) @(posedge sys_clk);
        xfer(1'b1, OFF_CONTROL, 8'h00);
        chk(mons != 0, 1'b1);
        rd24(OFF_OSC_LOW);
        chk(cnt != 24'h00_0000, 1'b1);
        i = int'(cnt);
        mons = 0;
        repeat (60) @(posedge sys_clk);
        rd24(OFF_OSC_LOW);
        chk(cnt, 24'(i));
        chk(mons, 0);
        wrap_up();
    end
endmodule : test_rc_oscillation_adc_counters
